// [shared/fwc_defs.svh]
`ifndef FWC_DEFS_SVH
`define FWC_DEFS_SVH

// register byte offsets within the 4 KiB window
`define FWC_OFS_STATUS      12'h400
`define FWC_OFS_MODE_CFG    12'h504
`define FWC_OFS_PAGE_ERASE  12'h508
`define FWC_OFS_FULL_ERASE  12'h50c
`define FWC_OFS_PAGE_ERS_B  12'h510
`define FWC_OFS_USER_ERASE  12'h514
`define FWC_OFS_CHUNK_ERASE 12'h518
`define FWC_OFS_CHUNK_DUR   12'h51c
`define FWC_OFS_ERASE_CYC   12'h520

// field positions and reset values
`define FWC_MODE_LSB        0
`define FWC_MODE_W          2
`define FWC_DUR_W           7
`define FWC_STATUS_RST      32'h0000_0001
`define FWC_MODE_RST        2'h0
`define FWC_DUR_RST         7'h0a
`define FWC_MODE_RO         2'h0
`define FWC_MODE_WEN        2'h1
`define FWC_MODE_EEN        2'h2

// timing, in their own units; cycle counts are derived in the controller
`define FWC_CLK_MHZ         100
`define FWC_WRITE_TIME_US   40
`define FWC_PAGE_WIPE_MS    2
`define FWC_FULL_WIPE_MS    4
`define FWC_MS_NS           1000000
`define FWC_CLK_NS          10

`endif

// [shared/fwc_pkg.sv]
package fwc_pkg;

  // operation issued to the flash array
  typedef enum logic [2:0] {
    FWC_OP_NONE,
    FWC_OP_PROG,
    FWC_OP_PAGE,
    FWC_OP_USER,
    FWC_OP_ALL,
    FWC_OP_CHUNK
  } fwc_op_e;

  typedef enum logic [1:0] {
    FWC_ST_IDLE,
    FWC_ST_PROG,
    FWC_ST_ERASE
  } fwc_state_e;

  // cpu access toward the flash address space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fwc_fl_req_s;

  // command to the flash array, start is a one-cycle pulse
  typedef struct packed {
    logic        start;
    fwc_op_e     op;
    logic [31:0] addr;
    logic [31:0] data;
  } fwc_arr_cmd_s;

endpackage

// [src/fwc_op_timer.sv]
`timescale 1ns/1ps
module fwc_op_timer #(
  parameter int CNT_W = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_r;
  logic             done_r;

  // down counter; a zero load still lasts one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (start)
      cnt_r <= (cycles == '0) ? CNT_W'(1) : cycles;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - CNT_W'(1);
  end

  // done marks the cycle after the last counted one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else
      done_r <= !start && (cnt_r == CNT_W'(1));
  end

  assign busy = (cnt_r != '0);
  assign done = done_r;

endmodule

// [src/fwc_ahb_regif.sv]
`timescale 1ns/1ps
module fwc_ahb_regif (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] rd_data,
  output logic [11:0]      rd_addr,
  output logic             wr_en,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  logic        accept;
  logic        dph_wr_r;
  logic [11:0] dph_addr_r;
  logic [31:0] hrdata_r;

  // only whole-word writes act; narrower writes complete with no effect
  assign accept  = hsel && htrans[1] && hready;
  assign rd_addr = {haddr[11:2], 2'b00};

  // latch the address phase of a write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 12'h000;
    end
    else if (hready)
    begin
      dph_wr_r   <= accept && hwrite && (hsize == 3'h2);
      dph_addr_r <= {haddr[11:2], 2'b00};
    end
  end

  // read data sampled at the address phase so it stands from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (accept && !hwrite)
      hrdata_r <= rd_data;
  end

  // zero wait state, always OKAY
  assign wr_en     = dph_wr_r;
  assign wr_addr   = dph_addr_r;
  assign wr_data   = hwdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

endmodule

// [src/fwc_flash_controller.sv]
// What this block does
// - program only whole 32-bit words at word-aligned addresses while writing enabled
// - programming only clears bits to 0; only erase brings back ones
// - byte or halfword writes to flash are refused with a hard fault
// - each word program lasts the write time with the cpu stalled throughout
// - page erase command erases one code page within page wipe time
// - during erases the cpu stalls only when fetching code from flash or when a legal word write waits in write mode
// - user area words program like flash; new values apply after reset
// - user area write-count limit holds, though this block keeps no write count; cpu stalls during each word write
// - user area erase command sets the whole user area to ones
// - full erase wipes flash and user area, factory area untouched
// - chunk erase applies only to code area pages, never the user area
// - chunk erase command runs one chunk for the configured duration
// - page erased when accumulated chunk time in ms reaches page wipe time; counts erase cycles
// - page contents undefined while accumulated chunk time is below threshold
// - status bit 0 reads 0 while busy, 1 when idle, resets to 1
// - mode field bits 1:0: 0 read only, 1 write, 2 erase; resets 0
`timescale 1ns/1ps
`include "fwc_defs.svh"
module fwc_flash_controller
  import fwc_pkg::*;
#(
  parameter int          NUM_PAGES     = 48,
  parameter int          PAGE_BYTES    = 4096,
  parameter logic [31:0] USER_BASE     = 32'h1000_1000,
  parameter int          MS_CYC        = `FWC_MS_NS / `FWC_CLK_NS,
  parameter int          PAGE_WIPE_CYC = `FWC_PAGE_WIPE_MS * MS_CYC,
  parameter int          FULL_WIPE_CYC = `FWC_FULL_WIPE_MS * MS_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire fwc_fl_req_s fl_req,
  input  wire logic        cpu_fetch_flash,
  output logic             fl_stall,
  output logic             fl_fault,
  output fwc_arr_cmd_s     arr_cmd,
  output logic [NUM_PAGES-1:0] page_undefined
);

  // word write time in whole cycles, never less than one
  localparam int WRITE_CYC = (`FWC_WRITE_TIME_US * `FWC_CLK_MHZ < 1) ? 1 :
                             `FWC_WRITE_TIME_US * `FWC_CLK_MHZ;
  localparam int PG_W      = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1;
  localparam int ACC_W     = 9;
  localparam logic [31:0] CODE_BYTES = 32'(NUM_PAGES * PAGE_BYTES);

  // cycles of a chunk of the given length in ms
  function automatic logic [31:0] chunk_cycles(input logic [`FWC_DUR_W-1:0] ms);
    logic [63:0] prod;
    prod = 64'(ms) * 64'(MS_CYC);
    return prod[31:0];
  endfunction

  // page index of a code address
  function automatic logic [PG_W-1:0] page_of(input logic [31:0] addr);
    logic [31:0] idx;
    idx = addr / 32'(PAGE_BYTES);
    return idx[PG_W-1:0];
  endfunction

  // bus side of the register file
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;

  fwc_ahb_regif u_regif (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );

  fwc_state_e                 state_r;
  logic [`FWC_MODE_W-1:0]     mode_r;
  logic [`FWC_DUR_W-1:0]      dur_r;
  logic [31:0]                pg_addr_r;
  logic [31:0]                chunk_addr_r;
  logic                       full_bit_r;
  logic                       user_bit_r;
  logic [31:0]                erase_cyc_r;
  logic [ACC_W-1:0]           acc_r [NUM_PAGES];
  logic [NUM_PAGES-1:0]       undef_r;
  fwc_arr_cmd_s               cmd_r;
  logic                       fault_r;

  logic        tmr_start;
  logic [31:0] tmr_cycles;
  logic        tmr_busy;
  logic        tmr_done;

  fwc_op_timer #(
    .CNT_W (32)
  ) u_timer (
    .clk    (hclk),
    .rst_n  (hresetn),
    .start  (tmr_start),
    .cycles (tmr_cycles),
    .busy   (tmr_busy),
    .done   ()
  );
  assign tmr_done = (state_r != FWC_ST_IDLE) && !tmr_busy && !cmd_r.start;

  // decode of incoming requests
  logic idle;
  logic wen;
  logic een;
  logic cmd_wr;
  logic fl_wr;
  logic fl_legal;
  logic prog_go;
  logic in_code_chunk;
  logic [PG_W-1:0]  chunk_pg;
  logic [ACC_W-1:0] acc_sum;
  logic             chunk_full;

  assign idle     = (state_r == FWC_ST_IDLE);
  assign wen      = (mode_r == `FWC_MODE_WEN);
  assign een      = (mode_r == `FWC_MODE_EEN);
  assign fl_wr    = fl_req.valid && fl_req.write;
  assign fl_legal = (fl_req.size == 3'h2) && (fl_req.addr[1:0] == 2'b00);
  assign prog_go  = fl_wr && fl_legal && wen && idle;
  // commands are only taken in erase mode and when idle; others vanish
  assign cmd_wr   = wr_en && een && idle;

  assign in_code_chunk = (wr_data < CODE_BYTES);
  assign chunk_pg      = page_of(wr_data);
  assign acc_sum       = acc_r[chunk_pg] + ACC_W'(dur_r);
  assign chunk_full    = (acc_sum >= ACC_W'(`FWC_PAGE_WIPE_MS));

  // which operation starts this cycle and for how long
  fwc_op_e     go_op;
  logic [31:0] go_addr;
  always_comb
  begin
    go_op      = FWC_OP_NONE;
    go_addr    = 32'h0000_0000;
    tmr_cycles = 32'h0000_0000;
    if (prog_go)
    begin
      go_op      = FWC_OP_PROG;
      go_addr    = fl_req.addr;
      tmr_cycles = 32'(WRITE_CYC);
    end
    else if (cmd_wr)
    begin
      case (wr_addr)
        `FWC_OFS_PAGE_ERASE, `FWC_OFS_PAGE_ERS_B:
        begin
          go_op      = FWC_OP_PAGE;
          go_addr    = wr_data;
          tmr_cycles = 32'(PAGE_WIPE_CYC);
        end
        `FWC_OFS_FULL_ERASE:
        begin
          if (wr_data[0])
          begin
            go_op      = FWC_OP_ALL;
            tmr_cycles = 32'(FULL_WIPE_CYC);
          end
        end
        `FWC_OFS_USER_ERASE:
        begin
          if (wr_data[0])
          begin
            go_op      = FWC_OP_USER;
            go_addr    = USER_BASE;
            tmr_cycles = 32'(PAGE_WIPE_CYC);
          end
        end
        `FWC_OFS_CHUNK_ERASE:
        begin
          if (in_code_chunk)
          begin
            // the finishing chunk is issued as a page wipe to the array
            go_op      = chunk_full ? FWC_OP_PAGE : FWC_OP_CHUNK;
            go_addr    = wr_data;
            tmr_cycles = chunk_cycles(dur_r);
          end
        end
        default:
        begin
          go_op = FWC_OP_NONE;
        end
      endcase
    end
  end
  assign tmr_start = (go_op != FWC_OP_NONE);

  // operation sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= FWC_ST_IDLE;
    else
    begin
      case (state_r)
        FWC_ST_IDLE:
        begin
          if (go_op == FWC_OP_PROG)
            state_r <= FWC_ST_PROG;
          else if (go_op != FWC_OP_NONE)
            state_r <= FWC_ST_ERASE;
        end
        FWC_ST_PROG, FWC_ST_ERASE:
        begin
          if (tmr_done)
            state_r <= FWC_ST_IDLE;
        end
        default:
        begin
          state_r <= FWC_ST_IDLE;
        end
      endcase
    end
  end

  // array command: data is what gets anded into the cell, never sets a bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd_r <= '{start: 1'b0, op: FWC_OP_NONE, addr: 32'h0, data: 32'hffff_ffff};
    else
    begin
      cmd_r.start <= tmr_start;
      if (tmr_start)
      begin
        cmd_r.op   <= go_op;
        cmd_r.addr <= go_addr;
        cmd_r.data <= (go_op == FWC_OP_PROG) ? fl_req.wdata : 32'hffff_ffff;
      end
    end
  end
  assign arr_cmd = cmd_r;

  // hard fault on narrow or unaligned writes, in any mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fault_r <= 1'b0;
    else
      fault_r <= fl_wr && !fl_legal;
  end
  assign fl_fault = fault_r;

  // a waiting legal program also stalls so it is not lost behind an erase
  assign fl_stall = (state_r == FWC_ST_PROG)
                  || ((state_r == FWC_ST_ERASE) && cpu_fetch_flash)
                  || (fl_wr && fl_legal && wen && !idle);

  // software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= `FWC_MODE_RST;
      dur_r  <= `FWC_DUR_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == `FWC_OFS_MODE_CFG)
        mode_r <= wr_data[`FWC_MODE_LSB +: `FWC_MODE_W];
      if (wr_addr == `FWC_OFS_CHUNK_DUR)
        dur_r <= wr_data[`FWC_DUR_W-1:0];
    end
  end

  // readback copies of the command registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pg_addr_r    <= 32'h0000_0000;
      chunk_addr_r <= 32'h0000_0000;
      full_bit_r   <= 1'b0;
      user_bit_r   <= 1'b0;
    end
    else if (wr_en)
    begin
      if (wr_addr == `FWC_OFS_PAGE_ERASE || wr_addr == `FWC_OFS_PAGE_ERS_B)
        pg_addr_r <= wr_data;
      if (wr_addr == `FWC_OFS_CHUNK_ERASE)
        chunk_addr_r <= wr_data;
      if (wr_addr == `FWC_OFS_FULL_ERASE)
        full_bit_r <= wr_data[0];
      if (wr_addr == `FWC_OFS_USER_ERASE)
        user_bit_r <= wr_data[0];
    end
  end

  // accumulated chunk time per page and the undefined-contents marks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_PAGES; i++)
        acc_r[i] <= '0;
      undef_r <= '0;
    end
    else if (tmr_start && wr_addr == `FWC_OFS_CHUNK_ERASE && !prog_go)
    begin
      acc_r[chunk_pg]   <= chunk_full ? '0 : acc_sum;
      undef_r[chunk_pg] <= !chunk_full;
    end
    else if (go_op == FWC_OP_PAGE)
    begin
      acc_r[page_of(go_addr)]   <= '0;
      undef_r[page_of(go_addr)] <= 1'b0;
    end
    else if (go_op == FWC_OP_ALL)
    begin
      for (int i = 0; i < NUM_PAGES; i++)
        acc_r[i] <= '0;
      undef_r <= '0;
    end
  end
  assign page_undefined = undef_r;

  // erase cycles completed by chunking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      erase_cyc_r <= 32'h0000_0000;
    else if (tmr_start && !prog_go && wr_addr == `FWC_OFS_CHUNK_ERASE && chunk_full)
      erase_cyc_r <= erase_cyc_r + 32'h0000_0001;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    case (rd_addr)
      `FWC_OFS_STATUS:      rd_data = {31'h0, idle};
      `FWC_OFS_MODE_CFG:    rd_data = {30'h0, mode_r};
      `FWC_OFS_PAGE_ERASE:  rd_data = pg_addr_r;
      `FWC_OFS_PAGE_ERS_B:  rd_data = pg_addr_r;
      `FWC_OFS_FULL_ERASE:  rd_data = {31'h0, full_bit_r};
      `FWC_OFS_USER_ERASE:  rd_data = {31'h0, user_bit_r};
      `FWC_OFS_CHUNK_ERASE: rd_data = chunk_addr_r;
      `FWC_OFS_CHUNK_DUR:   rd_data = {25'h0, dur_r};
      `FWC_OFS_ERASE_CYC:   rd_data = erase_cyc_r;
      default:              rd_data = 32'h0000_0000;
    endcase
  end

endmodule

// [bench/fwc_flash_controller_assertions.sv]
`timescale 1ns/1ps
module fwc_chk
  import fwc_pkg::*;
#(
  parameter int NUM_PAGES = 48
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire fwc_fl_req_s          fl_req,
  input wire logic                 cpu_fetch_flash,
  input wire logic                 fl_stall,
  input wire logic                 fl_fault,
  input wire fwc_arr_cmd_s         arr_cmd,
  input wire logic [NUM_PAGES-1:0] page_undefined
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic bad_wr;
  logic prog;
  logic erase;
  // decoded causes; erase covers every wipe kind, not word writes
  assign bad_wr = fl_req.valid && fl_req.write
                  && (fl_req.size != 3'h2 || fl_req.addr[1:0] != 2'h0);
  assign prog   = arr_cmd.start && arr_cmd.op == FWC_OP_PROG;
  assign erase  = arr_cmd.start && arr_cmd.op inside {FWC_OP_PAGE, FWC_OP_USER, FWC_OP_ALL,
                                                      FWC_OP_CHUNK};

  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  AST_FAULT: assert property (bad_wr |=> fl_fault)
    else $error("bad write gave no fault");
  AST_NO_FAULT: assert property (!bad_wr |=> !fl_fault)
    else $error("fault without bad write");
  AST_PROG_CAPT: assert property (prog |->
    arr_cmd.addr == $past(fl_req.addr) && arr_cmd.data == $past(fl_req.wdata))
    else $error("program word not taken from cpu");
  AST_PROG_STALL: assert property (prog |-> fl_stall [*8])
    else $error("cpu not stalled while programming");
  AST_START_PULSE: assert property (arr_cmd.start |=> !arr_cmd.start)
    else $error("start longer than one cycle");
  AST_ERASE_QUIET: assert property (erase && !cpu_fetch_flash && !fl_req.valid |-> !fl_stall)
    else $error("erase stalled a cpu not fetching");
  AST_ERASE_FETCH: assert property (erase && cpu_fetch_flash |-> fl_stall)
    else $error("fetch not stalled during erase");
  AST_CHUNK_UNDEF: assert property (arr_cmd.start && arr_cmd.op == FWC_OP_CHUNK |->
    ##[0:2] (|page_undefined))
    else $error("chunk left no page undefined");
  AST_ALL_CLEARS: assert property (arr_cmd.start && arr_cmd.op == FWC_OP_ALL |->
    ##[0:2] page_undefined == '0)
    else $error("full erase left a page undefined");

  // main scenarios reached
  cover property (prog);
  cover property (erase && cpu_fetch_flash);
  cover property (arr_cmd.start && arr_cmd.op == FWC_OP_CHUNK);
  cover property (fl_fault);
endmodule

bind fwc_flash_controller fwc_chk #(.NUM_PAGES(NUM_PAGES)) u_fwc_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .fl_req(fl_req),
  .cpu_fetch_flash(cpu_fetch_flash), .fl_stall(fl_stall), .fl_fault(fl_fault),
  .arr_cmd(arr_cmd), .page_undefined(page_undefined));

// [bench/fwc_flash_array_model.sv]
`timescale 1ns/1ps
module fwc_flash_array_model
  import fwc_pkg::*;
#(
  parameter int PAGE_BYTES = 4096
) (
  input wire logic         hclk,
  input wire fwc_arr_cmd_s arr_cmd
);
  // only the first words of page 0 are kept; enough to see clearing and wiping
  logic [31:0] mem [8];

  initial
    foreach (mem[i])
      mem[i] = 32'hffffffff;

  function automatic logic [31:0] peek(input int i);
    return mem[i];
  endfunction

  // commands act at start; the controller owns the timing
  always @(posedge hclk)
    if (arr_cmd.start === 1'b1)
      foreach (mem[i])
        case (arr_cmd.op)
          FWC_OP_PROG: if (arr_cmd.addr == 32'(i * 4)) mem[i] = mem[i] & arr_cmd.data;
          FWC_OP_PAGE: if (arr_cmd.addr < PAGE_BYTES) mem[i] = 32'hffffffff;
          FWC_OP_CHUNK: if (arr_cmd.addr < PAGE_BYTES) mem[i] = 32'hxxxxxxxx;
          FWC_OP_ALL: mem[i] = 32'hffffffff;
          default: ;
        endcase
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb
  import fwc_pkg::*;
;
  localparam int MS = 10;
  localparam int PW = 20;
  localparam int FW = 40;
  localparam int NP = 4;
  localparam int WC = 4000;

  logic          hclk;
  logic          hresetn;
  logic          hwrite;
  logic          rd_ph;
  logic          cpu_fetch_flash;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic [31:0]   d1;
  logic [31:0]   d2;
  logic          hreadyout;
  logic          hresp;
  logic          fl_stall;
  logic          fl_fault;
  fwc_fl_req_s   fl_req;
  fwc_arr_cmd_s  arr_cmd;
  logic [NP-1:0] page_undefined;
  logic [34:0]   e;
  logic [34:0]   rq[$];
  logic [34:0]   cq[$];
  int            n_errors = 0;
  int            checks = 0;
  int            cyc = 0;
  int            seed;
  int            n;

  fwc_flash_controller #(.NUM_PAGES(NP), .MS_CYC(MS), .PAGE_WIPE_CYC(PW), .FULL_WIPE_CYC(FW))
  u_fwc_flash_controller (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_req(fl_req),
    .cpu_fetch_flash(cpu_fetch_flash), .fl_stall(fl_stall), .fl_fault(fl_fault),
    .arr_cmd(arr_cmd), .page_undefined(page_undefined));
  fwc_flash_array_model u_fwc_flash_array_model (.hclk(hclk), .arr_cmd(arr_cmd));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [34:0] ex, input logic [34:0] got);
    checks++;
    if (got !== ex)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one single word transfer; the master waits on hready, never on a count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    rq.push_back({3'h0, ex});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // cpu word write: request for one cycle, then count stalled cycles
  task automatic prog(input logic [31:0] a, input logic [31:0] d, output int k);
    fl_req <= '{1'b1, 1'b1, 3'h2, a, d};
    @(posedge hclk);
    fl_req.valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (fl_stall === 1'b1);
  endtask

  // outputs are matched against the oldest note; addresses of full and user area wipes are not compared
  always @(posedge hclk)
  begin
    if (rd_ph === 1'b1)
      chk("hrdata", rq.pop_front(), {3'h0, hrdata});
    if (arr_cmd.start === 1'b1)
    begin
      e = (cq.size() > 0) ? cq.pop_front() : '1;
      chk("op", {32'h0, e[34:32]}, {32'h0, arr_cmd.op});
      if (e[34:32] inside {FWC_OP_PROG, FWC_OP_PAGE, FWC_OP_CHUNK})
        chk("addr", {3'h0, e[31:0]}, {3'h0, arr_cmd.addr});
    end
  end

  // hang guard, well above the three word writes
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    seed = 32'hae38;
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_ph = 1'b0;
    fl_req = '0;
    cpu_fetch_flash = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, an unmapped offset, requests in read only mode
    rd(12'h400, 32'h1);
    rd(12'h504, 32'h0);
    rd(12'h51c, 32'ha);
    rd(12'h600, 32'h0);
    prog(32'h0, 32'h0, n);
    chk("idle stall", 35'h1, 35'(n));
    wr(12'h508, 32'h0);
    rd(12'h400, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      wr(12'h504, 32'(m));
      rd(12'h504, 32'(m));
    end
    // two chunks on page 1 reach the wipe time; user area is refused
    wr(12'h51c, 32'h1);
    cq.push_back({FWC_OP_CHUNK, 32'h1000});
    wr(12'h518, 32'h1000);
    rd(12'h400, 32'h0);
    repeat (MS + 5) @(posedge hclk);
    chk("undefined", 35'h2, 35'(page_undefined));
    cq.push_back({FWC_OP_PAGE, 32'h1000});
    wr(12'h518, 32'h1000);
    repeat (MS + 5) @(posedge hclk);
    rd(12'h520, 32'h1);
    chk("undefined", 35'h0, 35'(page_undefined));
    wr(12'h518, 32'h1000_1000);
    rd(12'h400, 32'h1);
    // word writes: random data, then a partial update keeping upper bits
    wr(12'h504, 32'h1);
    d1 = $random(seed);
    cq.push_back({FWC_OP_PROG, 32'h0});
    prog(32'h0, d1, n);
    chk("write time", 35'h1, {34'h0, n >= WC && n <= WC + 3});
    d2 = $random(seed) | 32'hffff0000;
    cq.push_back({FWC_OP_PROG, 32'h0});
    prog(32'h0, d2, n);
    chk("word", {3'h0, d1 & d2}, {3'h0, u_fwc_flash_array_model.peek(0)});
    cq.push_back({FWC_OP_PROG, 32'h1000_1000});
    prog(32'h1000_1000, d1, n);
    rd(12'h400, 32'h1);
    fl_req <= '{1'b1, 1'b1, 3'h0, 32'h5, d1};
    @(posedge hclk);
    fl_req <= '{1'b1, 1'b1, 3'h2, 32'h6, d1};
    @(posedge hclk);
    chk("fault", 35'h1, {34'h0, fl_fault});
    fl_req.valid <= 1'b0;
    // page wipes by both offsets, a second command while busy is dropped
    wr(12'h504, 32'h2);
    for (int i = 0; i < 2; i++)
    begin
      cpu_fetch_flash <= i[0];
      cq.push_back({FWC_OP_PAGE, 32'h0});
      wr(i[0] ? 12'h510 : 12'h508, 32'h0);
      wr(12'h50c, 32'h1);
      repeat (PW + 5) @(posedge hclk);
      chk("wiped", {3'h0, 32'hffffffff}, {3'h0, u_fwc_flash_array_model.peek(0)});
    end
    // half a page erase, then full and user area wipes
    cq.push_back({FWC_OP_CHUNK, 32'h0});
    wr(12'h518, 32'h0);
    repeat (MS + 5) @(posedge hclk);
    chk("undefined", 35'h1, 35'(page_undefined));
    cq.push_back({FWC_OP_ALL, 32'h0});
    wr(12'h50c, 32'h1);
    repeat (FW + 5) @(posedge hclk);
    chk("undefined", 35'h0, 35'(page_undefined));
    chk("all", {3'h0, 32'hffffffff}, {3'h0, u_fwc_flash_array_model.peek(0)});
    wr(12'h514, 32'h0);
    rd(12'h400, 32'h1);
    cq.push_back({FWC_OP_USER, 32'h0});
    wr(12'h514, 32'h1);
    repeat (PW + 5) @(posedge hclk);
    rd(12'h400, 32'h1);
    wr(12'h504, 32'h0);
    rd(12'h504, 32'h0);
    repeat (2) @(posedge hclk);
    chk("pending ops", 35'h0, 35'(cq.size()));
    finish_test();
  end
endmodule
